// [common/lpm_pkg.sv]
// Package for the link power-state manager: state codes and timing constants.
// Assumes a single 200 MHz system clock.
package lpm_pkg;

    // Clock period in picoseconds
    localparam int CLK_PERIOD_PS = 5000;

    // Link power states, one-hot
    typedef enum logic [6:0] {
        LPM_LDN   = 7'h01,
        LPM_L0    = 7'h02,
        LPM_L1    = 7'h04,
        LPM_L1_EX = 7'h08,
        LPM_L23_E = 7'h10,
        LPM_L23R  = 7'h20,
        LPM_L2    = 7'h40
    } lpm_state_t;

    // Encoded state report
    localparam logic [2:0] ST_CODE_LDN = 3'h0;
    localparam logic [2:0] ST_CODE_L0  = 3'h1;
    localparam logic [2:0] ST_CODE_L1  = 3'h2;
    localparam logic [2:0] ST_CODE_L23 = 3'h3;
    localparam logic [2:0] ST_CODE_L2  = 3'h4;
    localparam logic [2:0] ST_CODE_L3  = 3'h5;

    // Idle time before ASPM entry, in nanoseconds
    localparam int IDLE_L0S_NS = 1000;
    localparam int IDLE_L1_NS  = 10000;
    localparam int IDLE_L0S_CYC = (IDLE_L0S_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int IDLE_L1_CYC  = (IDLE_L1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Longest L0s exit, 100 symbol times at 4 ns, rounded down
    localparam int L0S_EXIT_NS  = 400;
    localparam int L0S_EXIT_CYC = (L0S_EXIT_NS * 1000) / CLK_PERIOD_PS;

    // L1 exit wait, in nanoseconds, with and without the PLL kept on
    localparam int L1_EXIT_ON_NS   = 2000;
    localparam int L1_EXIT_OFF_NS  = 8000;
    localparam int L1_EXIT_ON_CYC  = (L1_EXIT_ON_NS * 1000) / CLK_PERIOD_PS;
    localparam int L1_EXIT_OFF_CYC = (L1_EXIT_OFF_NS * 1000) / CLK_PERIOD_PS;

    localparam int CNT_W = 12;

endpackage

// [src/lpm_timer.sv]
// Down-counter with load and done pulse, used for idle and exit timing.
// Assumes load values fit the counter width.
`timescale 1ns/1ps
module lpm_timer #(
    parameter int W = 12
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    input  wire logic         run,
    // Status
    output logic              done
);
    logic [W-1:0] count;
    wire          at_one = (count == W'(1));

    always_ff @(posedge clk_sys) begin
        if (rst || load) begin
            count <= rst ? '0 : value;
        end else if (run && count != '0) begin
            count <= count - W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        done <= !rst && !load && run && at_one;
    end
endmodule

// [src/lpm_core.sv]
// Link power-state manager for one downstream port of a serial packet link.
// Assumes the physical layer reports training and electrical idle; all inputs
// from the link side are asynchronous and are synchronised here.
// How it works
// - In L0 every packet type may pass; gates are open.
// - Transmitter in L0s sends nothing until it is back in L0.
// - L0s is entered only by ASPM idle timing, never by D-state.
// - Clocks and PLL stay on in L0s; exit within 100 symbol times.
// - Transmit L0s is tracked separately from the partner's receive L0s.
// - Enter L1 when all functions leave D0, or an acked ASPM request.
// - Leave L1 on partner traffic or our own pending transmit.
// - No packets cross the link in L1; traffic resumes only in L0.
// - PLL may be shut off in L1; reference clock stays on.
// - L1 exit waits a few microseconds, shorter when PLL stays on.
// - The L2/L3 Ready transition is always implemented.
// - After sending the turn-off ack, start L2/L3 Ready entry at once.
// - L2/L3 Ready entry begins by sending the enter-L23 DLLP.
// - No packets in L2/L3 Ready; main power may then be removed.
// - Leaving L2/L3 Ready goes through link-down training, never to L0.
// - Report link-down while training is in any pre-L0 training state.
// - Turn-off while in L1 first returns to L0, then to L2/L3 Ready.
// - Turn-off in L0 with active functions still acks and goes to L23.
// - No packets in L2; main power and reference clock are off.
// - In L2 only wake and PME keep-alive run on auxiliary power.
// - Auxiliary power is drawn only when software enables it.
// - ASPM moves an idle link down and returns on traffic unless disabled.
`timescale 1ns/1ps
module lpm_core (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Physical layer status, asynchronous
    input  wire logic       phy_trained,
    input  wire logic       phy_training,
    input  wire logic       rx_elec_idle,
    input  wire logic       main_power_good,
    // Traffic requests, same clock
    input  wire logic       tx_pending,
    input  wire logic       rx_l1_req_ack,
    input  wire logic       turn_off_rcvd,
    input  wire logic       to_ack_sent,
    input  wire logic       enter_l23_sent,
    // Configuration, same clock
    input  wire logic       all_funcs_non_d0,
    input  wire logic       aspm_l0s_en,
    input  wire logic       aspm_l1_en,
    input  wire logic       pll_off_in_l1_en,
    input  wire logic       aux_power_en,
    // Traffic gating
    output logic            tlp_tx_allow,
    output logic            dllp_tx_allow,
    output logic            rx_allow,
    // Handshakes toward the data link layer
    output logic            send_l1_req,
    output logic            send_enter_l23,
    output logic            send_to_ack,
    // Power and clock control
    output logic            tx_l0s,
    output logic            pll_enable,
    output logic            refclk_req,
    output logic            aux_power_draw,
    output logic            wake_logic_on,
    output logic            retrain_req,
    // State report
    output logic [2:0]      link_state
);
    lpm_pkg::lpm_state_t state;
    lpm_pkg::lpm_state_t next_state;

    // Two-stage synchronisers for asynchronous inputs
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    always_ff @(posedge clk_sys) begin
        sync_a <= {main_power_good, rx_elec_idle, phy_training, phy_trained};
        sync_b <= sync_a;
    end
    wire trained   = sync_b[0];
    wire training  = sync_b[1];
    wire rx_idle   = sync_b[2];
    wire power_ok  = sync_b[3];

    // Idle detection and timers
    wire link_busy = tx_pending || !rx_idle;
    wire in_l0     = (state == lpm_pkg::LPM_L0);
    wire in_l1     = (state == lpm_pkg::LPM_L1);
    wire in_l1_ex  = (state == lpm_pkg::LPM_L1_EX);
    wire in_l23e   = (state == lpm_pkg::LPM_L23_E);

    logic l0s_exit;
    logic turn_off_pend;
    logic l1_req_pend;

    wire l0s_idle_done;
    wire l1_idle_done;
    wire l0s_exit_done;
    wire l1_exit_done;
    wire entering_l1_ex = in_l1 && next_state == lpm_pkg::LPM_L1_EX;
    wire [lpm_pkg::CNT_W-1:0] l1_exit_val = pll_off_in_l1_en ?
        lpm_pkg::CNT_W'(lpm_pkg::L1_EXIT_OFF_CYC) :
        lpm_pkg::CNT_W'(lpm_pkg::L1_EXIT_ON_CYC);

    // Only idle timing under ASPM starts L0s, no D-state term
    // Partner traffic does not hold off our L0s; a pending turn-off does
    lpm_timer #(.W(lpm_pkg::CNT_W)) u_l0s_idle (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (!in_l0 || tx_pending || turn_off_pend || tx_l0s),
        .value   (lpm_pkg::CNT_W'(lpm_pkg::IDLE_L0S_CYC)),
        .run     (aspm_l0s_en),
        .done    (l0s_idle_done)
    );
    lpm_timer #(.W(lpm_pkg::CNT_W)) u_l1_idle (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (!in_l0 || link_busy),
        .value   (lpm_pkg::CNT_W'(lpm_pkg::IDLE_L1_CYC)),
        .run     (aspm_l1_en),
        .done    (l1_idle_done)
    );
    lpm_timer #(.W(lpm_pkg::CNT_W)) u_l0s_exit (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (!l0s_exit),
        .value   (lpm_pkg::CNT_W'(lpm_pkg::L0S_EXIT_CYC)),
        .run     (1'b1),
        .done    (l0s_exit_done)
    );
    lpm_timer #(.W(lpm_pkg::CNT_W)) u_l1_exit (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (entering_l1_ex),
        .value   (l1_exit_val),
        .run     (in_l1_ex),
        .done    (l1_exit_done)
    );

    // Transmit-direction L0s, independent of the partner's direction
    wire l0s_enter = in_l0 && !tx_l0s && l0s_idle_done && aspm_l0s_en;
    // A turn-off must wake the transmitter, or the ack would never be sent
    wire l0s_wake  = tx_l0s && !l0s_exit && (tx_pending || turn_off_pend || !in_l0);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_l0s   <= 1'b0;
            l0s_exit <= 1'b0;
        end else begin
            tx_l0s   <= l0s_enter || (tx_l0s && !l0s_exit_done);
            l0s_exit <= l0s_wake || (l0s_exit && !l0s_exit_done);
        end
    end

    // Pending requests; a set in the clearing cycle wins
    wire l1_req_set = in_l0 && l1_idle_done && aspm_l1_en && !tx_l0s;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            turn_off_pend <= 1'b0;
            l1_req_pend   <= 1'b0;
        end else begin
            turn_off_pend <= turn_off_rcvd || (turn_off_pend && !to_ack_sent);
            l1_req_pend   <= l1_req_set || (l1_req_pend && !rx_l1_req_ack && in_l0
                             && !link_busy);
        end
    end

    // State transitions
    wire go_l1   = !turn_off_pend && !tx_l0s &&
                   (all_funcs_non_d0 || (l1_req_pend && rx_l1_req_ack));
    wire l1_wake = tx_pending || !rx_idle || turn_off_rcvd || turn_off_pend;

    always_comb begin
        next_state = state;
        unique case (state)
            lpm_pkg::LPM_LDN: begin
                if (trained && !training) begin
                    next_state = lpm_pkg::LPM_L0;
                end
            end
            lpm_pkg::LPM_L0: begin
                if (!trained || training) begin
                    next_state = lpm_pkg::LPM_LDN;
                end else if (turn_off_pend && to_ack_sent) begin
                    next_state = lpm_pkg::LPM_L23_E;
                end else if (go_l1) begin
                    next_state = lpm_pkg::LPM_L1;
                end
            end
            lpm_pkg::LPM_L1: begin
                if (l1_wake) begin
                    next_state = lpm_pkg::LPM_L1_EX;
                end
            end
            lpm_pkg::LPM_L1_EX: begin
                if (l1_exit_done) begin
                    next_state = lpm_pkg::LPM_L0;
                end
            end
            lpm_pkg::LPM_L23_E: begin
                if (enter_l23_sent) begin
                    next_state = lpm_pkg::LPM_L23R;
                end
            end
            lpm_pkg::LPM_L23R: begin
                if (!power_ok) begin
                    next_state = lpm_pkg::LPM_L2;
                end else if (training) begin
                    next_state = lpm_pkg::LPM_LDN;
                end
            end
            lpm_pkg::LPM_L2: begin
                if (power_ok) begin
                    next_state = lpm_pkg::LPM_LDN;
                end
            end
            default: next_state = lpm_pkg::LPM_LDN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= lpm_pkg::LPM_LDN;
        end else begin
            state <= next_state;
        end
    end

    // Gates: TLP open only in full L0 with the transmitter out of L0s; DLLP also in L23 entry, rx in all of L0
    wire next_l0   = (next_state == lpm_pkg::LPM_L0);
    wire tx_l0s_next = l0s_enter || (tx_l0s && !l0s_exit_done);
    wire tx_open   = next_l0 && !tx_l0s_next;
    wire l23_dllp  = (next_state == lpm_pkg::LPM_L23_E) && !tx_l0s_next;
    wire in_low    = (next_state == lpm_pkg::LPM_L2);
    wire pll_need  = !(in_low || (next_state == lpm_pkg::LPM_L1 && pll_off_in_l1_en));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tlp_tx_allow   <= 1'b0;
            dllp_tx_allow  <= 1'b0;
            rx_allow       <= 1'b0;
            send_l1_req    <= 1'b0;
            send_enter_l23 <= 1'b0;
            send_to_ack    <= 1'b0;
            pll_enable     <= 1'b1;
            refclk_req     <= 1'b1;
            aux_power_draw <= 1'b0;
            wake_logic_on  <= 1'b0;
            retrain_req    <= 1'b0;
            link_state     <= lpm_pkg::ST_CODE_LDN;
        end else begin
            tlp_tx_allow   <= tx_open;
            dllp_tx_allow  <= tx_open || l23_dllp;
            rx_allow       <= next_l0;
            send_l1_req    <= l1_req_set;
            send_enter_l23 <= l23_dllp && !enter_l23_sent;
            send_to_ack    <= turn_off_pend && in_l0 && !to_ack_sent && !tx_l0s;
            pll_enable     <= pll_need;
            refclk_req     <= !in_low;
            aux_power_draw <= in_low && aux_power_en;
            wake_logic_on  <= in_low && aux_power_en;
            retrain_req    <= (state == lpm_pkg::LPM_L2) && power_ok;
            unique case (next_state)
                lpm_pkg::LPM_LDN:   link_state <= lpm_pkg::ST_CODE_LDN;
                lpm_pkg::LPM_L0:    link_state <= lpm_pkg::ST_CODE_L0;
                lpm_pkg::LPM_L1,
                lpm_pkg::LPM_L1_EX: link_state <= lpm_pkg::ST_CODE_L1;
                lpm_pkg::LPM_L23_E,
                lpm_pkg::LPM_L23R:  link_state <= lpm_pkg::ST_CODE_L23;
                lpm_pkg::LPM_L2:    link_state <= aux_power_en ? lpm_pkg::ST_CODE_L2 :
                                                  lpm_pkg::ST_CODE_L3;
                default:            link_state <= lpm_pkg::ST_CODE_LDN;
            endcase
        end
    end
endmodule

// [tb/lpm_core_props.sv]
// Checker for the link power-state manager, bound to lpm_core.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module lpm_core_props (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Watched inputs
    input  wire logic       tx_pending,
    input  wire logic       to_ack_sent,
    input  wire logic       aspm_l0s_en,
    input  wire logic       aux_power_en,
    // Watched outputs
    input  wire logic       tlp_tx_allow,
    input  wire logic       dllp_tx_allow,
    input  wire logic       rx_allow,
    input  wire logic       send_enter_l23,
    input  wire logic       tx_l0s,
    input  wire logic       pll_enable,
    input  wire logic       refclk_req,
    input  wire logic       aux_power_draw,
    input  wire logic [2:0] link_state
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_l0_gates_open: assert property (link_state == lpm_pkg::ST_CODE_L0 && !tx_l0s
        |-> tlp_tx_allow && dllp_tx_allow) else $error("L0 gates closed");
    a_l0s_tx_quiet: assert property (tx_l0s |-> !tlp_tx_allow && !dllp_tx_allow)
        else $error("packet gate open in L0s");
    a_l0s_aspm_only: assert property ($rose(tx_l0s) |-> $past(aspm_l0s_en))
        else $error("L0s entered without ASPM");
    a_l0s_clocks_on: assert property (tx_l0s |-> pll_enable && refclk_req)
        else $error("clock off in L0s");
    // Bound covers the 80-cycle exit count plus the state update
    a_l0s_exit_bound: assert property (tx_l0s && tx_pending |-> ##[1:100] !tx_l0s)
        else $error("L0s exit too slow");
    a_l1_no_traffic: assert property (link_state == lpm_pkg::ST_CODE_L1
        |-> !tlp_tx_allow && !dllp_tx_allow && !rx_allow) else $error("traffic in L1");
    a_l1_refclk_on: assert property (link_state == lpm_pkg::ST_CODE_L1 |-> refclk_req)
        else $error("refclk off in L1");
    a_l23_enter_cause: assert property ($rose(send_enter_l23) |-> $past(to_ack_sent))
        else $error("L23 entry without ack");
    a_l23_no_tlp: assert property (link_state == lpm_pkg::ST_CODE_L23
        |-> !tlp_tx_allow && !rx_allow) else $error("traffic in L23 Ready");
    a_l23_exit_path: assert property (link_state == lpm_pkg::ST_CODE_L23
        ##1 link_state != lpm_pkg::ST_CODE_L23 |-> link_state != lpm_pkg::ST_CODE_L0)
        else $error("L23 Ready left straight to L0");
    a_l2_dark: assert property (link_state == lpm_pkg::ST_CODE_L2
        |-> !dllp_tx_allow && !refclk_req && !pll_enable) else $error("L2 not dark");
    a_aux_gated: assert property (!aux_power_en [*2] |-> !aux_power_draw)
        else $error("aux drawn while disabled");
    a_reset_ldn: assert property ($fell(rst) |-> link_state == lpm_pkg::ST_CODE_LDN
        && !tlp_tx_allow) else $error("not link-down after reset");
endmodule

bind lpm_core lpm_core_props i_lpm_core_props (.clk_sys, .rst, .tx_pending, .to_ack_sent,
    .aspm_l0s_en, .aux_power_en, .tlp_tx_allow, .dllp_tx_allow, .rx_allow, .send_enter_l23,
    .tx_l0s, .pll_enable, .refclk_req, .aux_power_draw, .link_state);

// [tb/lpm_partner.sv]
// Link partner model: idles its lanes when quiet and acknowledges requests.
// Assumes turn-off ack and enter-L23 requests from lpm_core are levels held until answered; the L1 request is a one-cycle pulse.
`timescale 1ns/1ps
module lpm_partner #(
    parameter int DLY = 12
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // From the bench and the port
    input  wire logic talk,
    input  wire logic send_to_ack,
    input  wire logic send_enter_l23,
    input  wire logic send_l1_req,
    // Toward the port
    output logic      rx_elec_idle,
    output logic      to_ack_sent,
    output logic      enter_l23_sent,
    output logic      rx_l1_req_ack
);
    logic [7:0] cnt;
    logic [1:0] req_q;
    // Our lanes idle on their own schedule, independent of the port
    assign rx_elec_idle = !talk;
    // Answer delay restarts whenever the request set changes
    always_ff @(posedge clk_sys) begin
        req_q <= {send_to_ack, send_enter_l23};
        if (rst || req_q != {send_to_ack, send_enter_l23})
            cnt <= 8'h00;
        else if (cnt != 8'hFF)
            cnt <= cnt + 8'h01;
        to_ack_sent    <= !rst && send_to_ack && cnt == DLY[7:0];
        enter_l23_sent <= !rst && send_enter_l23 && !send_to_ack && cnt == DLY[7:0];
        rx_l1_req_ack  <= !rst && send_l1_req;
    end
endmodule

// [tb/lpm_core_tb_top.sv]
// Testbench for lpm_core: training, L0s, L1, turn-off and power removal.
// Assumes a 200 MHz clock; the partner model answers handshakes.
`timescale 1ns/1ps
module lpm_core_tb_top;
    localparam logic [2:0] S_LDN = lpm_pkg::ST_CODE_LDN;
    localparam logic [2:0] S_L0 = lpm_pkg::ST_CODE_L0;
    localparam logic [2:0] S_L1 = lpm_pkg::ST_CODE_L1;
    localparam logic [2:0] S_L23 = lpm_pkg::ST_CODE_L23;
    logic clk_sys = 1'b0, rst = 1'b1, phy_trained = 1'b0, phy_training = 1'b0;
    logic main_power_good = 1'b1, tx_pending = 1'b0, turn_off_rcvd = 1'b0, talk = 1'b0;
    logic all_funcs_non_d0 = 1'b0, aspm_l0s_en = 1'b0, aspm_l1_en = 1'b0;
    logic pll_off_in_l1_en = 1'b1, aux_power_en = 1'b1;
    logic rx_elec_idle, rx_l1_req_ack, to_ack_sent, enter_l23_sent, tlp_tx_allow;
    logic dllp_tx_allow, rx_allow, send_l1_req, send_enter_l23, send_to_ack, tx_l0s;
    logic pll_enable, refclk_req, aux_power_draw, wake_logic_on, retrain_req;
    logic [2:0] link_state;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;

    always #2.5 clk_sys = ~clk_sys;

    lpm_core i_lpm_core (.clk_sys, .rst, .phy_trained, .phy_training, .rx_elec_idle,
        .main_power_good, .tx_pending, .rx_l1_req_ack, .turn_off_rcvd, .to_ack_sent,
        .enter_l23_sent, .all_funcs_non_d0, .aspm_l0s_en, .aspm_l1_en, .pll_off_in_l1_en,
        .aux_power_en, .tlp_tx_allow, .dllp_tx_allow, .rx_allow, .send_l1_req, .send_enter_l23,
        .send_to_ack, .tx_l0s, .pll_enable, .refclk_req, .aux_power_draw, .wake_logic_on,
        .retrain_req, .link_state);
    lpm_partner i_lpm_partner (.clk_sys, .rst, .talk, .send_to_ack, .send_enter_l23,
        .send_l1_req, .rx_elec_idle, .to_ack_sent, .enter_l23_sent, .rx_l1_req_ack);

    task automatic results();
        $display("Totals: %0d checks, %0d mismatches", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0b seen %0b", what, exp, got);
        end
    endtask

    // Bounded wait on the reported state, then a compare
    task automatic wait_code(input logic [2:0] code, input int limit);
        n = 0;
        while (link_state !== code && n < limit) begin
            @(negedge clk_sys);
            n++;
        end
        chk("link_state", code, link_state);
    endtask

    task automatic t_train();
        repeat (16) @(negedge clk_sys);
        chk("state in reset", S_LDN, link_state);
        rst = 1'b0;
        phy_training = 1'b1;
        repeat (10) @(negedge clk_sys);
        chk("state while training", S_LDN, link_state);
        phy_training = 1'b0;
        phy_trained = 1'b1;
        wait_code(S_L0, 10);
        chk1("tlp gate", 1'b1, tlp_tx_allow);
        chk1("rx gate", 1'b1, rx_allow);
        $display("test train done");
    endtask

    task automatic t_l0s();
        aspm_l0s_en = 1'b1;
        talk = 1'b1;
        n = 0;
        while (tx_l0s !== 1'b1 && n < lpm_pkg::IDLE_L0S_CYC + 20) begin
            @(negedge clk_sys);
            n++;
        end
        chk1("tx_l0s after idle", 1'b1, tx_l0s);
        chk1("tlp gate in L0s", 1'b0, tlp_tx_allow);
        chk1("rx gate in L0s", 1'b1, rx_allow);
        tx_pending = 1'b1;
        n = 0;
        while (tx_l0s !== 1'b0 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        chk1("L0s exit in time", 1'b1, n <= lpm_pkg::L0S_EXIT_CYC + 4);
        tx_pending = 1'b0;
        aspm_l0s_en = 1'b0;
        $display("test l0s done");
    endtask

    task automatic t_l1_aspm();
        talk = 1'b0;
        pll_off_in_l1_en = 1'b0;
        aspm_l1_en = 1'b1;
        wait_code(S_L1, lpm_pkg::IDLE_L1_CYC + 50);
        chk1("rx gate in ASPM L1", 1'b0, rx_allow);
        chk1("pll kept on in L1", 1'b1, pll_enable);
        tx_pending = 1'b1;
        wait_code(S_L0, lpm_pkg::L1_EXIT_ON_CYC + 20);
        chk1("L1 exit with PLL on", 1'b1, n <= lpm_pkg::L1_EXIT_ON_CYC + 4);
        tx_pending = 1'b0;
        aspm_l1_en = 1'b0;
        pll_off_in_l1_en = 1'b1;
        $display("test l1 aspm done");
    endtask

    task automatic t_l1_off();
        talk = 1'b0;
        all_funcs_non_d0 = 1'b1;
        wait_code(S_L1, 3000);
        chk1("tlp gate in L1", 1'b0, tlp_tx_allow);
        chk1("refclk in L1", 1'b1, refclk_req);
        talk = 1'b1;
        turn_off_rcvd = 1'b1;
        @(negedge clk_sys);
        turn_off_rcvd = 1'b0;
        wait_code(S_L0, lpm_pkg::L1_EXIT_OFF_CYC + 50);
        wait_code(S_L23, 100);
        chk1("enter-L23 request", 1'b1, send_enter_l23);
        repeat (40) @(negedge clk_sys);
        chk1("dllp gate in L23 Ready", 1'b0, dllp_tx_allow);
        all_funcs_non_d0 = 1'b0;
        main_power_good = 1'b0;
        wait_code(lpm_pkg::ST_CODE_L2, 20);
        chk1("aux draw in L2", 1'b1, aux_power_draw);
        chk1("wake logic in L2", 1'b1, wake_logic_on);
        main_power_good = 1'b1;
        wait_code(S_LDN, 20);
        chk1("retrain request", 1'b1, retrain_req);
        wait_code(S_L0, 40);
        $display("test l1 turn-off done");
    endtask

    task automatic t_l0_off();
        aux_power_en = 1'b0;
        turn_off_rcvd = 1'b1;
        @(negedge clk_sys);
        turn_off_rcvd = 1'b0;
        wait_code(S_L23, 100);
        repeat (40) @(negedge clk_sys);
        main_power_good = 1'b0;
        wait_code(lpm_pkg::ST_CODE_L3, 20);
        chk1("aux draw disabled", 1'b0, aux_power_draw);
        $display("test l0 turn-off done");
    endtask

    // Run ceiling well above the sum of all bounded waits
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            results();
        end
    end

    initial begin
        t_train();
        t_l0s();
        t_l1_aspm();
        t_l1_off();
        t_l0_off();
        results();
    end
endmodule
